// ---- rtl/cpb_bus_if.sv ----
/*
   Host bus interface and synchronisation logic of a floating point coprocessor.
   Assumes i_clock is the doubled host clock and i_srst is the shared power-on clear.
   The core side is represented by the i_core_* inputs; the core itself lives elsewhere.
*/
// Functional notes
// - Raise occupied on a recognised instruction, hold until execution ends.
// - Request operand whenever the data FIFO can take or give one while occupied.
// - Assert fault on a numeric exception during execution.
// - Clock source select picks core clock; bus stays on host clock.
// - Power management is disabled in asynchronous clock mode.
// - Cycle done only asserts during I/O cycles selecting the device.
// - Internal bus clock is i_clock halved, phased by reset.
// - Sample address, direction and command select in the strobe clock.
// - State machine idles after reset and after non-pipelined cycles.
// - Second clock enters ready-sense; stay while cycle end inactive.
// - Pipeline state starts every pipelined cycle, never non-pipelined ones.
// - Track every host cycle regardless of chip selects.
// - Ordinary writes get cycle done in first ready-sense clock.
// - Reads and env or state loads get cycle done in second ready-sense; the code slows only reads, as is_slow_write never matches.
// - Fastest write takes address clock plus one ready-sense clock.
// - Latch data bus on each falling internal edge in ready-sense of writes.
// - Cycle end in non-pipelined cycle goes idle, new strobe same clock.
// - Take part only when selected; float all outputs when chip disabled.
// - Drive read data from first ready-sense, float on move to idle.
// - Strobe plus cycle end in ready-sense goes pipeline, then back.
module cpb_bus_if
   import cpb_pkg::*;
(
   input  wire logic                i_clock,
   input  wire logic                i_srst,
   input  wire logic                i_addr_strobe_n,
   input  wire logic                i_cycle_end_in_n,
   input  wire logic                i_write_not_read,
   input  wire logic                i_command_select_n,
   input  wire logic                i_chip_enable,
   input  wire logic                i_select_low_n,
   input  wire logic                i_select_high,
   input  wire logic                i_clock_source_select,
   input  wire logic [DATA_W-1:0]   i_data_bus,
   output logic      [DATA_W-1:0]   o_data_bus,
   output logic                     o_data_bus_oe,
   output logic                     o_cycle_done_out_n,
   output logic                     o_cycle_done_out_oe,
   output logic                     o_engine_occupied_n,
   output logic                     o_operand_request,
   output logic                     o_fault_flag_n,
   output logic                     o_handshake_oe,
   output logic                     o_core_async_mode,
   output logic                     o_power_mgmt_enable,
   output logic                     o_bus_phase,
   input  wire logic                i_core_done,
   input  wire logic                i_core_fifo_ready,
   input  wire logic                i_core_exception,
   input  wire logic [DATA_W-1:0]   i_core_read_data,
   output logic      [DATA_W-1:0]   o_core_write_data,
   output logic                     o_core_write_valid,
   output cpb_req_t                 o_core_req
);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_READY_SENSE,
      ST_PIPELINE
   } cpb_state_t;

   // Sampling selects and decoding the cycle type at one place.
   function automatic logic is_selected(input cpb_cycle_def_t d);
      return d.chip_enable && !d.select_low_n && d.select_high;
   endfunction

   function automatic logic is_slow_write(input logic [DATA_W-1:0] opc);
      return ((opc[OPCODE_W-1:0] & OPC_OP_MASK) == OPC_ENV_LOAD) ||
             ((opc[OPCODE_W-1:0] & OPC_OP_MASK) == OPC_ST_REST);
   endfunction

   localparam int NSYNC = 11;

   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] sync_in;
   logic [NSYNC-1:0] sync_rst;

   assign raw_in   = {i_addr_strobe_n, i_cycle_end_in_n, i_chip_enable, i_select_low_n,
                      i_select_high, i_command_select_n, i_write_not_read,
                      i_clock_source_select, i_core_done, i_core_fifo_ready, i_core_exception};
   assign sync_rst = 11'h7c0;

   cpb_sync2 #(.WIDTH(NSYNC)) u_sync (
      .i_clock   (i_clock),
      .i_srst    (i_srst),
      .i_async   (raw_in),
      .i_rst_val (sync_rst),
      .o_sync    (sync_in)
   );

   cpb_cycle_def_t cdef;
   logic           ready_in;
   logic           async_mode;
   logic           core_done;
   logic           fifo_ready;
   logic           core_exc;

   // The cycle end line sits between strobe and chip enable in the bundle, so skip it.
   assign cdef       = cpb_cycle_def_t'({sync_in[10], sync_in[8:4]});
   assign ready_in   = !sync_in[9];
   assign async_mode = sync_in[3];
   assign core_done  = sync_in[2];
   assign fifo_ready = sync_in[1];
   assign core_exc   = sync_in[0];

   // Data is captured in lockstep with the control lines so a write word lines up with its clock.
   logic [DATA_W-1:0] data_s1;
   logic [DATA_W-1:0] data_s2;
   always_ff @(posedge i_clock) begin
      data_s1 <= i_srst ? DATA_RST : i_data_bus;
      data_s2 <= i_srst ? DATA_RST : data_s1;
   end

   // Internal bus clock phase; reset aligns it with the host.
   logic phase;
   logic next_phase;
   logic rise;
   logic fall;

   always_comb begin
      next_phase = i_srst ? 1'b0 : !phase;
   end
   assign rise = !phase;
   assign fall = phase;

   cpb_state_t state;
   cpb_state_t next_state;
   cpb_req_t   cur;
   cpb_req_t   next_cur;
   logic [1:0] rs_count;
   logic [1:0] next_rs_count;
   logic       last_opc_slow;
   logic       next_last_opc_slow;
   logic       strobe;

   assign strobe = !cdef.strobe_n;

   always_comb begin
      next_state         = state;
      next_cur           = cur;
      next_rs_count      = rs_count;
      next_last_opc_slow = last_opc_slow;
      if (rise) begin
         unique case (state)
            ST_IDLE: begin
               if (strobe) begin
                  next_state   = ST_READY_SENSE;
                  next_cur.valid = is_selected(cdef);
                  next_cur.dir   = cdef.write_not_read;
                  next_cur.kind  = cdef.command_select_n;
                  // Reads are slow; data words only with last_opc_slow set, which is_slow_write never does; a new opcode is not.
                  next_cur.slow  = (cdef.write_not_read == CPB_READ) ||
                                   (last_opc_slow && cdef.command_select_n == CPB_SEL_DATA);
                  next_rs_count  = 2'h0;
               end
            end
            ST_READY_SENSE: begin
               next_rs_count = (rs_count == 2'h3) ? rs_count : rs_count + 2'h1;
               if (ready_in && strobe) begin
                  next_state     = ST_PIPELINE;
                  next_cur.valid = is_selected(cdef);
                  next_cur.dir   = cdef.write_not_read;
                  next_cur.kind  = cdef.command_select_n;
                  next_cur.slow  = (cdef.write_not_read == CPB_READ) ||
                                   (last_opc_slow && cdef.command_select_n == CPB_SEL_DATA);
               end else if (ready_in) begin
                  next_state     = ST_IDLE;
                  next_cur.valid = 1'b0;
               end
               if (ready_in && cur.valid && cur.dir == CPB_WRITE &&
                   cur.kind == CPB_SEL_CTRL) begin
                  next_last_opc_slow = is_slow_write(data_s2);
               end
            end
            ST_PIPELINE: begin
               next_state    = ST_READY_SENSE;
               next_rs_count = 2'h0;
            end
            default: next_state = ST_IDLE;
         endcase
      end
      if (i_srst) begin
         next_state         = ST_IDLE;
         next_cur           = '0;
         next_rs_count      = 2'h0;
         next_last_opc_slow = 1'b0;
      end
   end

   always_ff @(posedge i_clock) begin
      phase         <= next_phase;
      state         <= next_state;
      cur           <= next_cur;
      rs_count      <= next_rs_count;
      last_opc_slow <= next_last_opc_slow;
   end

   // Outputs: cycle done, data bus, write latch.
   logic              in_rs;
   logic              done_now;
   logic              next_done_n;
   logic              next_data_oe;
   logic [DATA_W-1:0] next_data_out;
   logic [DATA_W-1:0] next_wdata;
   logic              next_wvalid;

   assign in_rs    = (state == ST_READY_SENSE);
   assign done_now = in_rs && cur.valid &&
                     (cur.slow ? (rs_count == 2'h1) : (rs_count == 2'h0));

   always_comb begin
      next_done_n   = o_cycle_done_out_n;
      next_data_oe  = o_data_bus_oe;
      next_data_out = o_data_bus;
      next_wdata    = o_core_write_data;
      next_wvalid   = 1'b0;
      if (fall) begin
         next_done_n  = !done_now;
         next_data_oe = in_rs && cur.valid && cur.dir == CPB_READ;
         if (in_rs && cur.valid && cur.dir == CPB_READ) begin
            next_data_out = i_core_read_data;
         end
         if (in_rs && cur.valid && cur.dir == CPB_WRITE) begin
            next_wdata  = data_s2;
            next_wvalid = 1'b1;
         end
      end
      if (i_srst) begin
         next_done_n   = 1'b1;
         next_data_oe  = 1'b0;
         next_data_out = DATA_RST;
         next_wdata    = DATA_RST;
         next_wvalid   = 1'b0;
      end
   end

   always_ff @(posedge i_clock) begin
      o_cycle_done_out_n <= next_done_n;
      o_data_bus_oe      <= next_data_oe;
      o_data_bus         <= next_data_out;
      o_core_write_data  <= next_wdata;
      o_core_write_valid <= next_wvalid;
   end

   assign o_cycle_done_out_oe = cdef.chip_enable;
   assign o_handshake_oe      = cdef.chip_enable;
   assign o_core_req          = cur;
   assign o_bus_phase         = phase;

   // Handshakes: occupied, operand request, fault.
   logic                  occupied;
   logic                  next_occupied;
   logic                  fault;
   logic                  next_fault;
   logic                  opnd_req;
   logic                  next_opnd_req;
   logic                  opcode_write;

   assign opcode_write = next_wvalid && cur.kind == CPB_SEL_CTRL;

   always_comb begin
      next_occupied = occupied;
      next_fault    = fault;
      next_opnd_req = occupied && fifo_ready;
      if (opcode_write) begin
         next_occupied = 1'b1;
      end else if (core_done) begin
         next_occupied = 1'b0;
      end
      if (occupied && core_exc) begin
         next_fault = 1'b1;
      end else if (!occupied) begin
         next_fault = 1'b0;
      end
      if (i_srst) begin
         next_occupied = 1'b0;
         next_fault    = 1'b0;
         next_opnd_req = 1'b0;
      end
   end

   always_ff @(posedge i_clock) begin
      occupied <= next_occupied;
      fault    <= next_fault;
      opnd_req <= next_opnd_req;
   end

   assign o_engine_occupied_n = !occupied;
   assign o_operand_request   = opnd_req;
   assign o_fault_flag_n      = !fault;

   // The power manager cannot gate a core clock it does not own in asynchronous mode.
   assign o_core_async_mode   = async_mode;
   assign o_power_mgmt_enable = !async_mode;

endmodule // cpb_bus_if

// ---- common/cpb_pkg.sv ----
/*
   Shared constants and types for the coprocessor host bus interface.
   Assumes a single 250 MHz design clock that stands for the doubled host clock.
*/
package cpb_pkg;

   localparam int  DATA_W        = 16;
   localparam int  OPCODE_W      = 11;
   localparam int  EXEC_CNT_W    = 8;
   localparam int  OPND_CNT_W    = 3;
   localparam int  ERR_GAP       = 6;
   localparam int  ERR_GAP_W     = 3;
   localparam int  CLK_PERIOD_NS = 4;
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
   localparam logic [10:0] OPC_ENV_LOAD  = 11'h10c;
   localparam logic [10:0] OPC_ST_REST   = 11'h52c;
   localparam logic [10:0] OPC_OP_MASK   = 11'h738;

   typedef enum logic {
      CPB_READ  = 1'b0,
      CPB_WRITE = 1'b1
   } cpb_dir_t;

   typedef enum logic {
      CPB_SEL_CTRL = 1'b0,
      CPB_SEL_DATA = 1'b1
   } cpb_kind_t;

   typedef struct packed {
      logic      strobe_n;
      logic      chip_enable;
      logic      select_low_n;
      logic      select_high;
      cpb_kind_t command_select_n;
      cpb_dir_t  write_not_read;
   } cpb_cycle_def_t;

   typedef struct packed {
      logic                valid;
      cpb_dir_t            dir;
      cpb_kind_t           kind;
      logic                slow;
   } cpb_req_t;

endpackage : cpb_pkg

// ---- rtl/cpb_sync2.sv ----
/*
   Two flip-flop synchroniser for a bundle of level inputs.
   Assumes the inputs may change at any time relative to i_clock.
*/
module cpb_sync2
   import cpb_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input  wire logic             i_clock,
   input  wire logic             i_srst,
   input  wire logic [WIDTH-1:0] i_async,
   input  wire logic [WIDTH-1:0] i_rst_val,
   output logic      [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_sync;

   always_comb begin
      next_stage1 = i_srst ? i_rst_val : i_async;
      next_sync   = i_srst ? i_rst_val : stage1;
   end

   // The reset value is a held level, loaded synchronously, so no port feeds an async path.
   always_ff @(posedge i_clock) begin
      stage1 <= next_stage1;
      o_sync <= next_sync;
   end

endmodule // cpb_sync2

// ---- verif/cpb_bus_if_chk.sv ----
/*
   Port checks for the coprocessor host bus interface.
   Assumes it is bound into every cpb_bus_if instance.
*/
module cpb_bus_if_chk
   import cpb_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_srst,
   input wire logic i_core_done,
   input wire logic i_core_fifo_ready,
   input wire logic o_cycle_done_out_n,
   input wire logic o_cycle_done_out_oe,
   input wire logic o_data_bus_oe,
   input wire logic o_engine_occupied_n,
   input wire logic o_fault_flag_n,
   input wire logic o_operand_request,
   input wire logic o_core_async_mode,
   input wire logic o_power_mgmt_enable,
   input wire logic o_bus_phase,
   input wire logic o_core_write_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] done_hist;
   logic [7:0] fifo_hist;

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_srst);

   // Histories cover the synchroniser delay, which the ports cannot show.
   always_ff @(posedge i_clock) begin
      done_hist <= {done_hist[6:0], i_core_done};
      fifo_hist <= {fifo_hist[6:0], i_core_fifo_ready};
   end

   chk_done_sel: assert property (!o_cycle_done_out_n |-> o_cycle_done_out_oe)
      else $error("done while unselected");
   chk_done_width: assert property ($fell(o_cycle_done_out_n) |=>
      !o_cycle_done_out_n ##1 o_cycle_done_out_n) else $error("done width");
   chk_float_off: assert property (!o_cycle_done_out_oe |-> !o_data_bus_oe)
      else $error("data driven while disabled");
   chk_pm_async: assert property (o_power_mgmt_enable != o_core_async_mode)
      else $error("power management in async mode");
   chk_phase_div: assert property (!$past(i_srst) && !$past(i_srst, 2) |->
      o_bus_phase != $past(o_bus_phase)) else $error("phase not halved");
   chk_busy_hold: assert property ($rose(o_engine_occupied_n) |-> |done_hist)
      else $error("occupied dropped early");
   chk_req_cause: assert property ($rose(o_operand_request) |-> |fifo_hist)
      else $error("request without fifo");
   chk_wv_pulse: assert property (o_core_write_valid |=> !o_core_write_valid)
      else $error("latch pulse too long");
   chk_fault_clear: assert property ($rose(o_engine_occupied_n) |->
      ##[0:4] o_fault_flag_n) else $error("fault outlives busy");
   chk_reset_quiet: assert property (disable iff (1'b0) i_srst |=>
      o_cycle_done_out_n && !o_data_bus_oe) else $error("reset not quiet");

   cov_done: cover property ($fell(o_cycle_done_out_n));
   cov_read: cover property (o_data_bus_oe ##1 !o_data_bus_oe);
   cov_async: cover property (o_core_async_mode && $fell(o_cycle_done_out_n));
endmodule // cpb_bus_if_chk

bind cpb_bus_if cpb_bus_if_chk u_chk (
   .i_clock, .i_srst, .i_core_done, .i_core_fifo_ready, .o_cycle_done_out_n,
   .o_cycle_done_out_oe, .o_data_bus_oe, .o_engine_occupied_n, .o_fault_flag_n,
   .o_operand_request, .o_core_async_mode, .o_power_mgmt_enable, .o_bus_phase,
   .o_core_write_valid
);

// ---- verif/cpb_host_model.sv ----
/*
   Host processor model that starts and ends coprocessor bus cycles.
   Assumes the bench calls run_cycle and i_clock is the doubled host clock.
*/
module cpb_host_model
   import cpb_pkg::*;
(
   input  wire logic              i_clock,
   input  wire logic              i_done_n,
   input  wire logic              i_phase,
   output cpb_cycle_def_t         o_def,
   output logic                   o_end_n,
   output logic      [DATA_W-1:0] o_data
);
   timeunit 1ns;
   timeprecision 1ps;
   time t_stb;

   initial begin
      o_def   = '{1'b1, 1'b1, 1'b0, 1'b1, CPB_SEL_DATA, CPB_READ};
      o_end_n = 1'b1;
      o_data  = '0;
      t_stb   = 0;
   end

   // Strobe starts on a fixed phase so that cycle latencies stay comparable.
   task automatic run_cycle(input cpb_dir_t dir, input cpb_kind_t kind,
                            input logic [1:0] sel, input logic [DATA_W-1:0] d, input int w);
      int n;
      n = 0;
      @(posedge i_clock);
      while (i_phase !== 1'b0) @(posedge i_clock);
      o_def  <= '{1'b0, sel[1], 1'b0, sel[0], kind, dir};
      o_data <= (dir == CPB_WRITE) ? d : ~o_data;
      t_stb  = $time;
      repeat (2) @(posedge i_clock);
      o_def.strobe_n <= 1'b1;
      while (sel == 2'b11 && i_done_n !== 1'b0 && n < 40) begin
         @(posedge i_clock);
         n++;
      end
      repeat (2 * w + 7 * (sel != 2'b11) + 1) @(posedge i_clock);
      o_end_n <= 1'b0;
      repeat (2) @(posedge i_clock);
      o_end_n <= 1'b1;
      o_data  <= ~o_data;
   endtask

   // The second strobe lands while the first cycle is in ready-sense; its data moves two clocks
   // later so that the first cycle's last latch still sees its own word.
   task automatic run_pipe(input logic [DATA_W-1:0] d0, input logic [DATA_W-1:0] d1);
      int n;
      n = 0;
      @(posedge i_clock);
      while (i_phase !== 1'b0) @(posedge i_clock);
      o_def  <= '{1'b0, 1'b1, 1'b0, 1'b1, CPB_SEL_DATA, CPB_WRITE};
      o_data <= d0;
      t_stb  = $time;
      repeat (2) @(posedge i_clock);
      o_def.strobe_n <= 1'b1;
      while (i_done_n !== 1'b0 && n < 40) begin
         @(posedge i_clock);
         n++;
      end
      @(posedge i_clock);
      while (i_phase !== 1'b0) @(posedge i_clock);
      o_def.strobe_n <= 1'b0;
      o_end_n        <= 1'b0;
      t_stb          = $time;
      repeat (2) @(posedge i_clock);
      o_def.strobe_n <= 1'b1;
      o_end_n        <= 1'b1;
      o_data         <= d1;
      n = 0;
      while (i_done_n !== 1'b0 && n < 40) begin
         @(posedge i_clock);
         n++;
      end
      @(posedge i_clock);
      o_end_n <= 1'b0;
      repeat (2) @(posedge i_clock);
      o_end_n <= 1'b1;
      o_data  <= ~o_data;
   endtask
endmodule // cpb_host_model

// ---- verif/cpb_bus_if_test.sv ----
/*
   Self-checking bench for the coprocessor host bus interface.
   Assumes the host model and the bound checker are compiled with it.
*/
module cpb_bus_if_test
   import cpb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic              rd;
      logic              slow;
      logic [DATA_W-1:0] d;
   } cpb_note_t;
   logic i_clock = 1'b0, i_srst = 1'b1, i_clock_source_select = 1'b0;
   logic i_core_done = 1'b0, i_core_fifo_ready = 1'b0, i_core_exception = 1'b0;
   logic [DATA_W-1:0] i_core_read_data = '0, hdata, o_data_bus, o_core_write_data;
   logic end_n, hs_oe, o_data_bus_oe, o_cycle_done_out_n, o_cycle_done_out_oe;
   logic o_engine_occupied_n;
   // Two synchroniser flops, then the strobe and first ready-sense internal clocks.
   localparam int LAT_FAST = 6;
   logic o_operand_request, o_fault_flag_n, o_core_async_mode, o_power_mgmt_enable, o_bus_phase;
   cpb_cycle_def_t def;
   cpb_note_t notes[$];
   logic [10:0] ops [3] = '{OPC_ENV_LOAD, OPC_ST_REST, 11'h001};
   int miscompares = 0, checked = 0, seed = 32'h58dab965;
   logic slow_mode = 1'b0;

   always #(CLK_PERIOD_NS / 2) i_clock = ~i_clock;

   cpb_bus_if u_dut (.i_clock, .i_srst, .i_addr_strobe_n(def.strobe_n), .i_cycle_end_in_n(end_n),
      .i_write_not_read(def.write_not_read), .i_command_select_n(def.command_select_n),
      .i_chip_enable(def.chip_enable), .i_select_low_n(def.select_low_n),
      .i_select_high(def.select_high), .i_clock_source_select, .i_data_bus(hdata), .o_data_bus,
      .o_data_bus_oe, .o_cycle_done_out_n, .o_cycle_done_out_oe, .o_engine_occupied_n,
      .o_operand_request, .o_fault_flag_n, .o_handshake_oe(hs_oe), .o_core_async_mode,
      .o_power_mgmt_enable, .o_bus_phase, .i_core_done, .i_core_fifo_ready, .i_core_exception,
      .i_core_read_data, .o_core_write_data, .o_core_write_valid(), .o_core_req());
   cpb_host_model u_host (.i_clock, .i_done_n(o_cycle_done_out_n), .i_phase(o_bus_phase),
      .o_def(def), .o_end_n(end_n), .o_data(hdata));

   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Every done pulse must match the oldest noted cycle; a spare pulse is an error.
   always @(posedge i_clock) begin
      cpb_note_t n;
      int lat;
      if (!i_srst && $fell(o_cycle_done_out_n)) begin
         lat = int'(($time - u_host.t_stb) / CLK_PERIOD_NS);
         if (notes.size() == 0) check(17'h1, 17'h0);
         else begin
            n = notes.pop_front();
            check(17'(lat), 17'(LAT_FAST + 2 * n.slow));
            if (n.rd) check({o_data_bus_oe, o_data_bus}, {1'b1, n.d});
         end
      end
   end

   task automatic xfer(input cpb_dir_t dir, input cpb_kind_t kind, input logic [1:0] sel,
                       input logic [DATA_W-1:0] d, input int w);
      logic rd;
      rd = (dir == CPB_READ);
      if (sel == 2'b11) notes.push_back('{rd, rd || (kind == CPB_SEL_DATA && slow_mode), d});
      if (sel == 2'b11 && !rd && kind == CPB_SEL_CTRL)
         slow_mode = (d[10:0] & OPC_OP_MASK) inside {OPC_ENV_LOAD, OPC_ST_REST};
      u_host.run_cycle(dir, kind, sel, d, w);
      repeat (2) @(posedge i_clock);
      if (sel == 2'b11 && !rd && kind == CPB_SEL_DATA)
         check({1'b0, o_core_write_data}, {1'b0, d});
   endtask

   // The pipeline state costs the second cycle one extra internal clock, noted as slow.
   task automatic pipe(input logic [DATA_W-1:0] d0, input logic [DATA_W-1:0] d1);
      notes.push_back('{1'b0, 1'b0, d0});
      notes.push_back('{1'b0, 1'b1, d1});
      u_host.run_pipe(d0, d1);
      repeat (2) @(posedge i_clock);
      check({1'b0, o_core_write_data}, {1'b0, d1});
   endtask

   task automatic opcode(input logic [DATA_W-1:0] d, input logic exc);
      int n;
      n = 0;
      xfer(CPB_WRITE, CPB_SEL_CTRL, 2'b11, d, 0);
      check({16'h0, o_engine_occupied_n}, 17'h0);
      if (exc) begin
         i_core_exception <= 1'b1;
         i_core_fifo_ready <= 1'b1;
         repeat (8) @(posedge i_clock);
         check({15'h0, o_fault_flag_n, o_operand_request}, 17'h1);
         i_core_exception <= 1'b0;
         i_core_fifo_ready <= 1'b0;
         repeat (8) @(posedge i_clock);
         check({15'h0, o_fault_flag_n, o_operand_request}, 17'h0);
      end
      i_core_done <= 1'b1;
      while (o_engine_occupied_n !== 1'b1 && n < 40) begin
         @(posedge i_clock);
         n++;
      end
      i_core_done <= 1'b0;
      repeat (2) @(posedge i_clock);
      check({15'h0, o_engine_occupied_n, o_fault_flag_n}, 17'h3);
   endtask

   initial begin
      repeat (20000) @(posedge i_clock);
      miscompares++;
      end_sim();
   end

   initial begin
      repeat (5) @(posedge i_clock);
      i_srst <= 1'b0;
      repeat (4) @(posedge i_clock);
      opcode(16'h0001, 1'b1);
      for (int i = 0; i < 8; i++)
         xfer(CPB_WRITE, CPB_SEL_DATA, 2'b11, 16'($random(seed)), i % 4);
      pipe(16'($random(seed)), 16'($random(seed)));
      $display("test writes done");
      for (int i = 0; i < 4; i++) begin
         i_core_read_data <= 16'($random(seed));
         @(posedge i_clock);
         xfer(CPB_READ, cpb_kind_t'(i % 2), 2'b11, i_core_read_data, i);
      end
      $display("test reads done");
      for (int k = 0; k < 3; k++) begin
         opcode({5'h00, ops[k]}, 1'b0);
         xfer(CPB_WRITE, CPB_SEL_DATA, 2'b11, 16'($random(seed)), 1);
      end
      $display("test slow loads done");
      xfer(CPB_WRITE, CPB_SEL_DATA, 2'b10, 16'h5a5a, 0);
      xfer(CPB_READ, CPB_SEL_DATA, 2'b01, 16'h0000, 0);
      check({14'h0, o_cycle_done_out_oe, hs_oe, o_data_bus_oe}, 17'h0);
      xfer(CPB_READ, CPB_SEL_CTRL, 2'b11, i_core_read_data, 0);
      $display("test selects done");
      // The core clock is the host clock here, a ratio of one, inside the allowed range.
      i_clock_source_select <= 1'b1;
      repeat (6) @(posedge i_clock);
      check({15'h0, o_core_async_mode, o_power_mgmt_enable}, 17'h2);
      xfer(CPB_WRITE, CPB_SEL_DATA, 2'b11, 16'hffff, 0);
      i_clock_source_select <= 1'b0;
      $display("test clock mode done");
      i_srst <= 1'b1;
      repeat (3) @(posedge i_clock);
      check({15'h0, o_cycle_done_out_n, o_data_bus_oe}, 17'h2);
      i_srst <= 1'b0;
      repeat (4) @(posedge i_clock);
      xfer(CPB_READ, CPB_SEL_DATA, 2'b11, i_core_read_data, 0);
      check({16'h0, 1'(notes.size() == 0)}, 17'h1);
      $display("test reset done");
      end_sim();
   end
endmodule // cpb_bus_if_test
